/* src/spcp_cfg.svh */
// Constants of the switch port configuration preload block
`ifndef SPCP_CFG_SVH
`define SPCP_CFG_SVH
// What this block does
// - Word 55h high byte to port2 44h[31:24]
// - Word 57h high byte to port3 44h[31:24]
// - Word 56h bit0 to port3 44h bit3
// - Word 56h bits3:1 to port3 40h[24:22]
// - Word 56h bit4 to port3 40h bit25
// - Word 56h bit5 to port3 40h bit26
// - Word 56h bits7:6 to port3 40h[29:28]
// - Ports0-2 word bit1 to D0h bit28
// - Ports0-2 word bit2 to 40h bit21
// - Ports0-2 word bit3 to 144h bit4
// - Ports0-2 word bits6:4 to CCh[26:24]
// - Ports0-2 word bits15:9 to 154h[7:1]
// - Ports1-2 word bit0 to C0h bit24

// ==========================================================
// Image word addresses, in load order
`define SPCP_IMG_P2PMD   8'h55
`define SPCP_IMG_P3PMC   8'h56
`define SPCP_IMG_P3PMD   8'h57
`define SPCP_IMG_P0SLOT  8'h60
`define SPCP_IMG_P1SLOT  8'h62
`define SPCP_IMG_P2SLOT  8'h64
`define SPCP_NUM_WORDS   3'h6
`define SPCP_NO_SLOT     3'h7

// ==========================================================
// Configuration dword offsets
`define SPCP_OFF_PMCAP   12'h040
`define SPCP_OFF_PMCSR   12'h044
`define SPCP_OFF_PCIECAP 12'h0C0
`define SPCP_OFF_LINKCAP 12'h0CC
`define SPCP_OFF_SLOTCLK 12'h0D0
`define SPCP_OFF_VCCAP   12'h144
`define SPCP_OFF_VCMAP   12'h154

// ==========================================================
// Field positions: image word side, dword side
`define SPCP_I_PMDATA    15:8
`define SPCP_D_PMDATA    31:24
`define SPCP_I_NSR       0
`define SPCP_D_NSR       3
`define SPCP_I_AUX       3:1
`define SPCP_D_AUX       24:22
`define SPCP_I_D1        4
`define SPCP_D_D1        25
`define SPCP_I_D2        5
`define SPCP_D_D2        26
`define SPCP_I_PME       7:6
`define SPCP_D_PME       29:28
`define SPCP_I_SLOTI     0
`define SPCP_D_SLOTI     24
`define SPCP_I_SCLK      1
`define SPCP_D_SCLK      28
`define SPCP_I_DSI       2
`define SPCP_D_DSI       21
`define SPCP_I_LPVC      3
`define SPCP_D_LPVC      4
`define SPCP_I_PNUM      6:4
`define SPCP_D_PNUM      26:24
`define SPCP_I_TCMAP     15:9
`define SPCP_D_TCMAP     7:1

// ==========================================================
// Reset values
`define SPCP_RST_DW      32'h0000_0000

// ==========================================================
// Local control and status registers
`define SPCP_OFF_CTRL    12'hF00
`define SPCP_OFF_STAT    12'hF04
`define SPCP_CTRL_RELOAD 0
`define SPCP_STAT_DONE   0
`define SPCP_STAT_BUSY   1
`define SPCP_STAT_TMO    2
`define SPCP_STAT_LOADED 13:8
`define SPCP_STAT_MISSED 21:16

// ==========================================================
// Timing
`define SPCP_TMO_CYC     1000
`endif

/* src/spcp_pkg.sv */
// Types of the switch port configuration preload block
package spcp_pkg;
	// Fetch sequencer states
	typedef enum logic [1:0] {SPCP_IDLE, SPCP_REQ, SPCP_STEP, SPCP_DONE} spcp_fsm_t;

	// One image word handed to the field stores
	typedef struct packed {
		logic        valid;
		logic [2:0]  slot;
		logic [15:0] data;
	} spcp_word_t;

	// The configuration dwords one port can hold
	typedef struct packed {
		logic [31:0] pmcap;
		logic [31:0] pmcsr;
		logic [31:0] pciecap;
		logic [31:0] linkcap;
		logic [31:0] slotclk;
		logic [31:0] vccap;
		logic [31:0] vcmap;
	} spcp_port_dw_t;

	// Fetch sequencer state
	typedef struct packed {
		spcp_fsm_t   fsm;
		logic [2:0]  slot;
		logic [15:0] tmo;
		logic        req;
		logic [7:0]  addr;
		spcp_word_t  word;
		logic        miss;
		logic        busy;
		logic        done;
	} spcp_fetch_st_t;

	// Field store state
	typedef struct packed {
		spcp_port_dw_t dw;
	} spcp_pf_st_t;

	// Top state
	typedef struct packed {
		logic [31:0] rdata;
		logic [5:0]  loaded;
		logic [5:0]  missed;
		logic        tmo_err;
		logic        start;
		logic        ready;
	} spcp_top_st_t;
endpackage : spcp_pkg

/* src/spcp_img_fetch.sv */
// Sequencer that reads the image words one after another
`timescale 1ns/1ps
`include "spcp_cfg.svh"
module spcp_img_fetch #(
	parameter int TMO_CYC = `SPCP_TMO_CYC
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               start,
	input  wire logic               img_ack,
	input  wire logic [15:0]        img_data,
	output logic                    img_req,
	output logic [7:0]              img_addr,
	output spcp_pkg::spcp_word_t    word,
	output logic                    miss,
	output logic                    busy,
	output logic                    done
);
	import spcp_pkg::*;

	// ==========================================================
	// Parameter check
	if (TMO_CYC < 1 || TMO_CYC > 65535) begin : g_bad_tmo
		$error("TMO_CYC out of range");
	end

	localparam logic [15:0] TMO_LAST = 16'(TMO_CYC - 1);

	spcp_fetch_st_t s_reg;
	spcp_fetch_st_t s_next;

	// Image address of each load slot
	function automatic logic [7:0] addr_of(input logic [2:0] slot);
		case (slot)
			3'h0:    addr_of = `SPCP_IMG_P2PMD;
			3'h1:    addr_of = `SPCP_IMG_P3PMC;
			3'h2:    addr_of = `SPCP_IMG_P3PMD;
			3'h3:    addr_of = `SPCP_IMG_P0SLOT;
			3'h4:    addr_of = `SPCP_IMG_P1SLOT;
			default: addr_of = `SPCP_IMG_P2SLOT;
		endcase
	endfunction : addr_of

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.word.valid = 1'b0;
		s_next.miss = 1'b0;
		case (s_reg.fsm)
			SPCP_IDLE, SPCP_DONE: begin
				if (start) begin
					s_next.slot = 3'h0;
					s_next.addr = addr_of(3'h0);
					s_next.req = 1'b1;
					s_next.tmo = 16'h0000;
					s_next.busy = 1'b1;
					s_next.done = 1'b0;
					s_next.fsm = SPCP_REQ;
				end
			end
			SPCP_REQ: begin
				if (img_ack) begin
					s_next.req = 1'b0;
					s_next.word = '{valid: 1'b1, slot: s_reg.slot, data: img_data};
					s_next.fsm = SPCP_STEP;
				end else if (s_reg.tmo == TMO_LAST) begin
					// Silent source: word skipped, field keeps its value
					s_next.req = 1'b0;
					s_next.miss = 1'b1;
					s_next.word.slot = s_reg.slot;
					s_next.fsm = SPCP_STEP;
				end else begin
					s_next.tmo = s_reg.tmo + 16'h0001;
				end
			end
			SPCP_STEP: begin
				if (s_reg.slot == `SPCP_NUM_WORDS - 3'h1) begin
					s_next.busy = 1'b0;
					s_next.done = 1'b1;
					s_next.fsm = SPCP_DONE;
				end else begin
					s_next.slot = s_reg.slot + 3'h1;
					s_next.addr = addr_of(s_reg.slot + 3'h1);
					s_next.req = 1'b1;
					s_next.tmo = 16'h0000;
					s_next.fsm = SPCP_REQ;
				end
			end
			default: begin
				s_next.fsm = SPCP_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '{fsm: SPCP_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign img_req  = s_reg.req;
	assign img_addr = s_reg.addr;
	assign word     = s_reg.word;
	assign miss     = s_reg.miss;
	assign busy     = s_reg.busy;
	assign done     = s_reg.done;
endmodule : spcp_img_fetch

/* src/spcp_port_fields.sv */
// Loaded configuration fields of one switch port
`timescale 1ns/1ps
`include "spcp_cfg.svh"
module spcp_port_fields #(
	parameter int PORT = 0
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  spcp_pkg::spcp_word_t    word,
	output spcp_pkg::spcp_port_dw_t dw
);
	import spcp_pkg::*;

	// ==========================================================
	// Parameter check and slot selection
	if (PORT < 0 || PORT > 3) begin : g_bad_port
		$error("PORT must be 0 to 3");
	end

	localparam logic [2:0] SET_SLOT = (PORT == 0) ? 3'h3 : (PORT == 1) ? 3'h4 :
		(PORT == 2) ? 3'h5 : `SPCP_NO_SLOT;
	localparam logic [2:0] PMD_SLOT = (PORT == 2) ? 3'h0 : (PORT == 3) ? 3'h2 :
		`SPCP_NO_SLOT;
	localparam logic [2:0] PMC_SLOT = (PORT == 3) ? 3'h1 : `SPCP_NO_SLOT;
	localparam logic       HAS_SLOTI = (PORT == 1 || PORT == 2);

	spcp_pf_st_t s_reg;
	spcp_pf_st_t s_next;

	// ==========================================================
	// Field loads from the incoming image word
	always_comb begin
		s_next = s_reg;
		if (word.valid && word.slot == PMD_SLOT) begin
			s_next.dw.pmcsr[`SPCP_D_PMDATA] = word.data[`SPCP_I_PMDATA];
		end
		if (word.valid && word.slot == PMC_SLOT) begin
			s_next.dw.pmcsr[`SPCP_D_NSR] = word.data[`SPCP_I_NSR];
			s_next.dw.pmcap[`SPCP_D_AUX] = word.data[`SPCP_I_AUX];
			s_next.dw.pmcap[`SPCP_D_D1]  = word.data[`SPCP_I_D1];
			s_next.dw.pmcap[`SPCP_D_D2]  = word.data[`SPCP_I_D2];
			s_next.dw.pmcap[`SPCP_D_PME] = word.data[`SPCP_I_PME];
		end
		if (word.valid && word.slot == SET_SLOT) begin
			s_next.dw.slotclk[`SPCP_D_SCLK] = word.data[`SPCP_I_SCLK];
			s_next.dw.pmcap[`SPCP_D_DSI]    = word.data[`SPCP_I_DSI];
			s_next.dw.vccap[`SPCP_D_LPVC]   = word.data[`SPCP_I_LPVC];
			s_next.dw.linkcap[`SPCP_D_PNUM] = word.data[`SPCP_I_PNUM];
			s_next.dw.vcmap[`SPCP_D_TCMAP]  = word.data[`SPCP_I_TCMAP];
			if (HAS_SLOTI) begin
				s_next.dw.pciecap[`SPCP_D_SLOTI] = word.data[`SPCP_I_SLOTI];
			end
		end
	end

	// Field register; defaults until a word arrives
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg.dw <= {7{`SPCP_RST_DW}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign dw = s_reg.dw;
endmodule : spcp_port_fields

/* src/spcp_loader.sv */
// Top of the switch port configuration preload block
`timescale 1ns/1ps
`include "spcp_cfg.svh"
module spcp_loader #(
	parameter int NUM_PORTS = 4,
	parameter int TMO_CYC   = `SPCP_TMO_CYC
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	output logic             IMG_REQ,
	output logic [7:0]       IMG_ADDR,
	input  wire logic        IMG_ACK,
	input  wire logic [15:0] IMG_DATA,
	input  wire logic [13:0] REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [31:0]      REG_RDATA,
	output logic             CFG_READY
);
	import spcp_pkg::*;

	// ==========================================================
	// Parameter check
	if (NUM_PORTS != 4) begin : g_bad_ports
		$error("NUM_PORTS must be 4");
	end

	spcp_top_st_t  s_reg;
	spcp_top_st_t  s_next;
	spcp_word_t    word;
	spcp_port_dw_t pdw [NUM_PORTS];
	logic          f_miss;
	logic          f_busy;
	logic          f_done;
	logic [1:0]    rd_port;
	logic [11:0]   rd_off;
	logic          ctl_hit;
	logic          reload;
	logic          tmo_clr;

	// ==========================================================
	// Image word sequencer
	spcp_img_fetch #(
		.TMO_CYC (TMO_CYC)
	) u_fetch (
		.clk_sys  (CLK_SYS),
		.rst      (RST),
		.start    (s_reg.start),
		.img_ack  (IMG_ACK),
		.img_data (IMG_DATA),
		.img_req  (IMG_REQ),
		.img_addr (IMG_ADDR),
		.word     (word),
		.miss     (f_miss),
		.busy     (f_busy),
		.done     (f_done)
	);

	// ==========================================================
	// One field store per port
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		spcp_port_fields #(
			.PORT (p)
		) u_fields (
			.clk_sys (CLK_SYS),
			.rst     (RST),
			.word    (word),
			.dw      (pdw[p])
		);
	end

	// ==========================================================
	// Register address split and local decode
	assign rd_port = REG_ADDR[13:12];
	assign rd_off  = REG_ADDR[11:0];
	assign ctl_hit = (rd_port == 2'h0);
	assign reload  = REG_WR && ctl_hit && rd_off == `SPCP_OFF_CTRL &&
		REG_WDATA[`SPCP_CTRL_RELOAD] && !f_busy && !s_reg.start;
	assign tmo_clr = REG_WR && ctl_hit && rd_off == `SPCP_OFF_STAT &&
		REG_WDATA[`SPCP_STAT_TMO];

	// ==========================================================
	// Next state: load start, status, read data
	always_comb begin
		s_next = s_reg;
		s_next.start = reload;
		// Ready once every word was fetched or skipped
		// Pending start masks the stale done of the last load
		if (reload) begin
			s_next.ready = 1'b0;
			s_next.loaded = 6'h00;
			s_next.missed = 6'h00;
		end else if (f_done && !s_reg.start) begin
			s_next.ready = 1'b1;
		end
		// Per-word bookkeeping
		if (word.valid) begin
			s_next.loaded[word.slot] = 1'b1;
		end
		if (f_miss) begin
			s_next.missed[word.slot] = 1'b1;
		end
		// Timeout flag, a new miss beats the clear
		if (f_miss) begin
			s_next.tmo_err = 1'b1;
		end else if (tmo_clr) begin
			s_next.tmo_err = 1'b0;
		end
		// Read data, zero for unmapped addresses
		s_next.rdata = 32'h0000_0000;
		if (REG_RD) begin
			case (rd_off)
				`SPCP_OFF_PMCAP:   s_next.rdata = pdw[rd_port].pmcap;
				`SPCP_OFF_PMCSR:   s_next.rdata = pdw[rd_port].pmcsr;
				`SPCP_OFF_PCIECAP: s_next.rdata = pdw[rd_port].pciecap;
				`SPCP_OFF_LINKCAP: s_next.rdata = pdw[rd_port].linkcap;
				`SPCP_OFF_SLOTCLK: s_next.rdata = pdw[rd_port].slotclk;
				`SPCP_OFF_VCCAP:   s_next.rdata = pdw[rd_port].vccap;
				`SPCP_OFF_VCMAP:   s_next.rdata = pdw[rd_port].vcmap;
				`SPCP_OFF_STAT: begin
					if (ctl_hit) begin
						s_next.rdata[`SPCP_STAT_DONE]   = s_reg.ready;
						s_next.rdata[`SPCP_STAT_BUSY]   = f_busy;
						s_next.rdata[`SPCP_STAT_TMO]    = s_reg.tmo_err;
						s_next.rdata[`SPCP_STAT_LOADED] = s_reg.loaded;
						s_next.rdata[`SPCP_STAT_MISSED] = s_reg.missed;
					end
				end
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// State register; reset kicks off the first load
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			s_reg <= '{start: 1'b1, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign REG_RDATA = s_reg.rdata;
	assign CFG_READY = s_reg.ready;
endmodule : spcp_loader

/* sim/spcp_img_src.sv */
// Behavioural model of the image source on the far side of the loader
`timescale 1ns/1ps
module spcp_img_src (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        img_req,
	input  wire logic [7:0]  img_addr,
	output logic             img_ack,
	output logic [15:0]      img_data
);
	logic [15:0] mem [0:5];
	int          lat = 0;
	logic [7:0]  skip = 8'h00;
	int          wait_cnt = 0;

	// Word slot of an image address
	function automatic int slot_of(input logic [7:0] a);
		case (a)
			8'h55: slot_of = 0;
			8'h56: slot_of = 1;
			8'h57: slot_of = 2;
			8'h60: slot_of = 3;
			8'h62: slot_of = 4;
			default: slot_of = 5;
		endcase
	endfunction : slot_of

	initial begin
		img_ack = 1'b0;
		img_data = 16'h0000;
	end

	// Answer after lat cycles; data toggles while not valid
	always @(posedge clk) begin
		img_ack <= 1'b0;
		img_data <= ~img_data;
		if (rst || !img_req || img_ack) begin
			wait_cnt <= 0;
		end else if (img_addr != skip) begin
			if (wait_cnt >= lat) begin
				img_ack <= 1'b1;
				img_data <= mem[slot_of(img_addr)];
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule : spcp_img_src

/* sim/spcp_loader_assertions.sv */
// Checker of the image fetch sequence and register read port
`timescale 1ns/1ps
module spcp_loader_assertions #(
	parameter int TMO_CYC = 4
) (
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        IMG_REQ,
	input wire logic [7:0]  IMG_ADDR,
	input wire logic        IMG_ACK,
	input wire logic [15:0] IMG_DATA,
	input wire logic [13:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        CFG_READY
);
	logic [7:0] last_reg;
	logic [7:0] nxt;
	int         req_cnt;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// ==========================================================
	// Helper logic
	// Last address requested and length of the current request
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			last_reg <= 8'h64;
			req_cnt <= 0;
		end else begin
			if (IMG_REQ) last_reg <= IMG_ADDR;
			req_cnt <= IMG_REQ ? req_cnt + 1 : 0;
		end
	end

	// Address that must follow the last one
	always_comb begin
		case (last_reg)
			8'h55: nxt = 8'h56;
			8'h56: nxt = 8'h57;
			8'h57: nxt = 8'h60;
			8'h60: nxt = 8'h62;
			8'h62: nxt = 8'h64;
			default: nxt = 8'h55;
		endcase
	end

	// ==========================================================
	// Assertions
	start_fetch_a: assert property ($fell(RST) |-> ##[1:3] (IMG_REQ && IMG_ADDR == 8'h55))
		else $error("load did not start after reset");
	word_order_a: assert property ($rose(IMG_REQ) |-> IMG_ADDR == nxt)
		else $error("image word out of order");
	req_drop_a: assert property (IMG_REQ && IMG_ACK |=> !IMG_REQ)
		else $error("request held after ack");
	addr_hold_a: assert property (IMG_REQ && !IMG_ACK |=> !IMG_REQ || $stable(IMG_ADDR))
		else $error("address moved during request");
	req_bound_a: assert property (req_cnt <= TMO_CYC + 1)
		else $error("request outlived timeout");
	ready_last_a: assert property (IMG_REQ && IMG_ACK && IMG_ADDR == 8'h64 |-> ##3 CFG_READY)
		else $error("ready late after last word");
	ready_idle_a: assert property (CFG_READY |-> !IMG_REQ)
		else $error("request while ready");
	ready_keep_a: assert property (CFG_READY && !REG_WR |=> CFG_READY)
		else $error("ready dropped without reload");
	rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h0)
		else $error("read data without read");
endmodule : spcp_loader_assertions

bind spcp_loader spcp_loader_assertions #(.TMO_CYC(TMO_CYC)) i_chk (
	.CLK_SYS(CLK_SYS), .RST(RST), .IMG_REQ(IMG_REQ), .IMG_ADDR(IMG_ADDR),
	.IMG_ACK(IMG_ACK), .IMG_DATA(IMG_DATA), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .CFG_READY(CFG_READY)
);

/* sim/tb_spcp_loader.sv */
// Self-checking bench of the switch port configuration preload block
`timescale 1ns/1ps
module tb_spcp_loader;
	localparam logic [11:0] OFFS [0:6] = '{12'h040, 12'h044, 12'h0C0, 12'h0CC,
		12'h0D0, 12'h144, 12'h154};
	localparam logic [7:0]  ADDRS [0:5] = '{8'h55, 8'h56, 8'h57, 8'h60, 8'h62, 8'h64};
	localparam logic [15:0] PAT [0:5] = '{16'hA5C3, 16'h00D5, 16'h3C00, 16'hFE5B,
		16'h81A7, 16'h5A3E};
	logic        CLK_SYS = 1'b0;
	logic        RST = 1'b1;
	logic [13:0] REG_ADDR = 14'h0;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic        IMG_REQ;
	logic        IMG_ACK;
	logic [7:0]  IMG_ADDR;
	logic [15:0] IMG_DATA;
	logic [31:0] REG_RDATA;
	logic        CFG_READY;
	logic [15:0] ld [0:5];
	logic [31:0] rd;
	logic [31:0] e;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	// Clock
	initial forever #20 CLK_SYS = ~CLK_SYS;

	spcp_loader #(.NUM_PORTS(4), .TMO_CYC(4)) i_dut (.CLK_SYS(CLK_SYS), .RST(RST),
		.IMG_REQ(IMG_REQ), .IMG_ADDR(IMG_ADDR), .IMG_ACK(IMG_ACK), .IMG_DATA(IMG_DATA),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA), .CFG_READY(CFG_READY));
	spcp_img_src i_src (.clk(CLK_SYS), .rst(RST), .img_req(IMG_REQ), .img_addr(IMG_ADDR),
		.img_ack(IMG_ACK), .img_data(IMG_DATA));

	// ==========================================================
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic reg_wr(input logic [13:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [13:0] a);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 rd = REG_RDATA;
	endtask : reg_rd

	// Image contents, slow answers and one word that never comes
	task automatic prep(input logic [15:0] x, input logic [7:0] skip, input int lat);
		for (int k = 0; k < 6; k++) begin
			i_src.mem[k] = PAT[k] ^ x;
			if (ADDRS[k] != skip) ld[k] = PAT[k] ^ x;
		end
		i_src.skip = skip;
		i_src.lat = lat;
	endtask : prep

	function automatic logic [31:0] exp_dw(input int p, input logic [11:0] o);
		logic [15:0] w;
		logic [31:0] d;
		d = 32'h0;
		w = (p < 3) ? ld[3 + p] : 16'h0;
		case (o)
			12'h040: d = (p == 3) ? {2'b0, ld[1][7:6], 1'b0, ld[1][5:4], ld[1][3:1], 22'h0}
				: {10'h0, w[2], 21'h0};
			12'h044: d = (p == 3) ? {ld[2][15:8], 20'h0, ld[1][0], 3'h0}
				: (p == 2) ? {ld[0][15:8], 24'h0} : 32'h0;
			12'h0C0: d = (p == 1 || p == 2) ? {7'h0, w[0], 24'h0} : 32'h0;
			12'h0CC: d = {5'h0, w[6:4], 24'h0};
			12'h0D0: d = {3'h0, w[1], 28'h0};
			12'h144: d = {27'h0, w[3], 4'h0};
			12'h154: d = {24'h0, w[15:9], 1'b0};
			default: d = 32'h0;
		endcase
		return d;
	endfunction : exp_dw

	task automatic check_all;
		for (int p = 0; p < 4; p++) begin
			for (int k = 0; k < 7; k++) begin
				reg_rd({p[1:0], OFFS[k]});
				e = exp_dw(p, OFFS[k]);
				check("field", rd, e);
				check("field", rd, e);
			end
		end
	endtask : check_all

	task automatic wait_ready;
		int n;
		n = 0;
		while (CFG_READY !== 1'b1 && n < 300) begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end
		check("ready", {31'h0, CFG_READY}, 32'h1);
	endtask : wait_ready

	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// Hang guard
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		prep(16'h0000, 8'h00, 0);
		repeat (8) @(posedge CLK_SYS);
		RST <= 1'b0;
		reg_rd(14'h0154);
		check("early", rd, 32'h0);
		wait_ready();
		check_all();
		reg_rd(14'h0F04);
		check("status", rd, 32'h0000_3F01);
		reg_wr(14'h10CC, 32'hFFFF_FFFF);
		reg_rd(14'h10CC);
		check("readonly", rd, exp_dw(1, 12'h0CC));
		reg_rd(14'h1300);
		check("unmapped", rd, 32'h0);
		// Slow reload with word 60h lost: port 0 keeps its old fields
		prep(16'hFFFF, 8'h60, 2);
		reg_wr(14'h0F00, 32'h1);
		#1 check("reload", {31'h0, CFG_READY}, 32'h0);
		wait_ready();
		check_all();
		reg_rd(14'h0F04);
		check("timeout", rd, 32'h0008_3705);
		reg_wr(14'h0F04, 32'h4);
		reg_rd(14'h0F04);
		check("cleared", rd, 32'h0008_3701);
		// Reset in mid-load clears the fields back to zero
		prep(16'h1234, 8'h00, 1);
		reg_wr(14'h0F00, 32'h1);
		repeat (5) @(posedge CLK_SYS);
		RST <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		RST <= 1'b0;
		reg_rd(14'h3044);
		check("cleared field", rd, 32'h0);
		wait_ready();
		check_all();
		wrap_up();
	end
endmodule : tb_spcp_loader
